// file: core/hcam_channel.sv
/*
 one current channel: threshold compare and monitor value with overflow.
 assumes qualified sample strobes from the phase timer of the top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hcam_cfg.svh"
module hcam_channel (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic present_i,
    input wire logic on_sample_i,
    input wire logic off_sample_i,
    input wire logic burnout_en_i,
    input wire logic overcur_en_i,
    input wire logic short_en_i,
    input wire hcam_pkg::cur_t current_i,
    input wire hcam_pkg::cur_t thr_burnout_i,
    input wire hcam_pkg::cur_t thr_overcur_i,
    input wire hcam_pkg::cur_t thr_short_i,
    output hcam_pkg::alarm_t alarm_o,
    output hcam_pkg::monitor_t monitor_o
);
    hcam_pkg::alarm_t alarm;
    hcam_pkg::alarm_t next_alarm;
    hcam_pkg::monitor_t mon;
    hcam_pkg::monitor_t next_mon;
    logic heat_en;

    function automatic hcam_pkg::cur_t to_monitor(input hcam_pkg::cur_t c);
        to_monitor = (c > `HCAM_MON_MAX) ? `HCAM_OVF_CODE : c;
    endfunction

    assign heat_en = burnout_en_i | overcur_en_i;

    always_comb begin
        next_alarm = alarm;
        next_mon = mon;
        if (on_sample_i && heat_en) begin
            next_mon.heater = to_monitor(current_i);
            if (burnout_en_i) begin
                if (thr_burnout_i == `HCAM_THR_OFF_LOW) begin
                    next_alarm.burnout = 1'b0;
                end else if (thr_burnout_i >= `HCAM_THR_FULL) begin
                    next_alarm.burnout = 1'b1;
                end else begin
                    next_alarm.burnout = current_i < thr_burnout_i;
                end
            end
            if (overcur_en_i) begin
                if (thr_overcur_i >= `HCAM_THR_FULL) begin
                    next_alarm.overcur = 1'b0;
                end else if (thr_overcur_i == `HCAM_THR_OFF_LOW) begin
                    next_alarm.overcur = 1'b1;
                end else begin
                    next_alarm.overcur = current_i > thr_overcur_i;
                end
            end
        end
        if (off_sample_i && short_en_i) begin
            next_mon.leak = to_monitor(current_i);
            if (thr_short_i >= `HCAM_THR_FULL) begin
                next_alarm.short_leak = 1'b0;
            end else if (thr_short_i == `HCAM_THR_OFF_LOW) begin
                next_alarm.short_leak = 1'b1;
            end else begin
                next_alarm.short_leak = current_i > thr_short_i;
            end
        end
        if (!burnout_en_i) begin
            next_alarm.burnout = 1'b0;
        end
        if (!overcur_en_i) begin
            next_alarm.overcur = 1'b0;
        end
        if (!heat_en) begin
            next_mon.heater = '0;
        end
        if (!short_en_i) begin
            next_alarm.short_leak = 1'b0;
            next_mon.leak = '0;
        end
        if (!present_i) begin
            next_alarm = '0;
            next_mon = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            alarm <= '0;
            mon <= '0;
        end else begin
            alarm <= next_alarm;
            mon <= next_mon;
        end
    end

    assign alarm_o = alarm;
    assign monitor_o = mon;
endmodule
`default_nettype wire

// file: core/heater_current_alarm_monitor.sv
/*
 heater current alarm monitor top: output phase timing, two channels,
 common lamp and display flash.
 assumes current samples arrive with a strobe, synchronous to clk_i.
*/
// How it works
// - burnout alarm when heater current with output on is below threshold
// - burnout threshold 0.0 A forces off, 50.0 A forces on
// - overcurrent alarm when heater current exceeds threshold
// - overcurrent threshold 50.0 A forces off, 0.0 A forces on
// - no burnout or overcurrent evaluation when on-time is 100 ms or less
// - leakage sampled only while off; skipped when off-time 100 ms or less
// - heater-short alarm when leakage current exceeds threshold
// - heater-short threshold 50.0 A forces off, 0.0 A forces on
// - monitors span 0.0 to 55.0 A; above reads FFFF
// - burnout or overcurrent on either channel lights lamp and flashes its monitor
// - heater-short alarm lights lamp and flashes that leakage monitor
// - heater monitoring only with burnout or overcurrent detection enabled
// - leakage monitoring only with heater-short alarm enabled
// - second channel exists only with two current inputs fitted
`timescale 1ns/1ps
`default_nettype none
`include "hcam_cfg.svh"
module heater_current_alarm_monitor #(
    parameter int MIN_PULSE_CYC = `HCAM_MIN_PULSE_CYC,
    parameter int BLINK_CYC = `HCAM_BLINK_CYC,
    parameter bit TWO_CT = 1'b1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic heat_out_i,
    input wire logic sample_valid_i,
    input wire hcam_pkg::cur_t ct1_current_i,
    input wire hcam_pkg::cur_t ct2_current_i,
    input wire logic burnout_detect_i,
    input wire logic overcur_use_i,
    input wire logic short_leak_alarm_i,
    input wire hcam_pkg::cur_t thr_burnout1_i,
    input wire hcam_pkg::cur_t thr_burnout2_i,
    input wire hcam_pkg::cur_t thr_overcur1_i,
    input wire hcam_pkg::cur_t thr_overcur2_i,
    input wire hcam_pkg::cur_t thr_short1_i,
    input wire hcam_pkg::cur_t thr_short2_i,
    output hcam_pkg::alarm_t alarm1_o,
    output hcam_pkg::alarm_t alarm2_o,
    output hcam_pkg::monitor_t monitor1_o,
    output hcam_pkg::monitor_t monitor2_o,
    output logic heater_alarm_lamp_o,
    output logic flash_heater1_o,
    output logic flash_heater2_o,
    output logic flash_leak1_o,
    output logic flash_leak2_o
);
    hcam_pkg::phase_t phase;
    hcam_pkg::phase_t next_phase;
    logic [31:0] run_cnt;
    logic [31:0] next_run_cnt;
    logic long_enough;
    logic next_long_enough;
    logic on_sample;
    logic off_sample;
    logic [31:0] blink_cnt;
    logic [31:0] next_blink_cnt;
    logic blink;
    logic next_blink;
    hcam_pkg::alarm_t a1;
    hcam_pkg::alarm_t a2;
    logic lamp;
    logic next_lamp;
    logic [3:0] flash;
    logic [3:0] next_flash;

    // time in the present output phase; qualified once above 100 ms
    always_comb begin
        next_phase = phase;
        next_run_cnt = run_cnt;
        next_long_enough = long_enough;
        case (phase)
            hcam_pkg::ST_IDLE: begin
                next_phase = heat_out_i ? hcam_pkg::ST_ON : hcam_pkg::ST_OFF;
                next_run_cnt = '0;
                next_long_enough = 1'b0;
            end
            hcam_pkg::ST_ON,
            hcam_pkg::ST_OFF: begin
                if (heat_out_i != (phase == hcam_pkg::ST_ON)) begin
                    next_phase = heat_out_i ? hcam_pkg::ST_ON
                                            : hcam_pkg::ST_OFF;
                    next_run_cnt = '0;
                    next_long_enough = 1'b0;
                end else if (!long_enough) begin
                    next_run_cnt = run_cnt + 32'h00000001;
                    next_long_enough =
                        (run_cnt >= 32'(MIN_PULSE_CYC));
                end
            end
            default: begin
                next_phase = hcam_pkg::ST_IDLE;
                next_run_cnt = '0;
                next_long_enough = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phase <= hcam_pkg::ST_IDLE;
            run_cnt <= '0;
            long_enough <= 1'b0;
        end else begin
            phase <= next_phase;
            run_cnt <= next_run_cnt;
            long_enough <= next_long_enough;
        end
    end

    // samples count only when taken in a phase that already lasted long
    assign on_sample = sample_valid_i && long_enough && heat_out_i
                       && (phase == hcam_pkg::ST_ON);
    assign off_sample = sample_valid_i && long_enough && !heat_out_i
                        && (phase == hcam_pkg::ST_OFF);

    hcam_channel u_ch1 (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .present_i(1'b1),
        .on_sample_i(on_sample),
        .off_sample_i(off_sample),
        .burnout_en_i(burnout_detect_i),
        .overcur_en_i(overcur_use_i),
        .short_en_i(short_leak_alarm_i),
        .current_i(ct1_current_i),
        .thr_burnout_i(thr_burnout1_i),
        .thr_overcur_i(thr_overcur1_i),
        .thr_short_i(thr_short1_i),
        .alarm_o(a1),
        .monitor_o(monitor1_o)
    );

    hcam_channel u_ch2 (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .present_i(TWO_CT),
        .on_sample_i(on_sample),
        .off_sample_i(off_sample),
        .burnout_en_i(burnout_detect_i),
        .overcur_en_i(overcur_use_i),
        .short_en_i(short_leak_alarm_i),
        .current_i(ct2_current_i),
        .thr_burnout_i(thr_burnout2_i),
        .thr_overcur_i(thr_overcur2_i),
        .thr_short_i(thr_short2_i),
        .alarm_o(a2),
        .monitor_o(monitor2_o)
    );

    // flash rate divider and common lamp
    always_comb begin
        next_blink_cnt = blink_cnt + 32'h00000001;
        next_blink = blink;
        if (blink_cnt >= 32'(BLINK_CYC - 1)) begin
            next_blink_cnt = '0;
            next_blink = ~blink;
        end
        next_lamp = a1.burnout | a1.overcur | a1.short_leak
                    | a2.burnout | a2.overcur | a2.short_leak;
        next_flash[0] = (a1.burnout | a1.overcur) & next_blink;
        next_flash[1] = (a2.burnout | a2.overcur) & next_blink;
        next_flash[2] = a1.short_leak & next_blink;
        next_flash[3] = a2.short_leak & next_blink;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            blink_cnt <= '0;
            blink <= 1'b0;
            lamp <= 1'b0;
            flash <= '0;
        end else begin
            blink_cnt <= next_blink_cnt;
            blink <= next_blink;
            lamp <= next_lamp;
            flash <= next_flash;
        end
    end

    assign alarm1_o = a1;
    assign alarm2_o = a2;
    assign heater_alarm_lamp_o = lamp;
    assign flash_heater1_o = flash[0];
    assign flash_heater2_o = flash[1];
    assign flash_leak1_o = flash[2];
    assign flash_leak2_o = flash[3];
endmodule
`default_nettype wire

// file: dv/hcam_assertions.sv
/*
 checker for the heater current alarm monitor top ports.
 assumes the bind in the testbench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module hcam_assertions (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic sample_valid_i,
    input wire logic heat_out_i,
    input wire logic burnout_detect_i,
    input wire logic overcur_use_i,
    input wire logic short_leak_alarm_i,
    input wire hcam_pkg::alarm_t alarm1_o,
    input wire hcam_pkg::alarm_t alarm2_o,
    input wire hcam_pkg::monitor_t monitor1_o,
    input wire logic heater_alarm_lamp_o,
    input wire logic flash_heater2_o,
    input wire logic flash_leak1_o
);
    logic [2:0] en;
    assign en = {burnout_detect_i, overcur_use_i, short_leak_alarm_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    AST_MON_RANGE: assert property (
        (monitor1_o.heater <= 16'h0226 || monitor1_o.heater == 16'hFFFF) &&
        (monitor1_o.leak <= 16'h0226 || monitor1_o.leak == 16'hFFFF))
        else $error("monitor value outside range");
    AST_LAMP: assert property ($past(resetn_i) |->
        heater_alarm_lamp_o == $past(|alarm1_o || |alarm2_o))
        else $error("lamp does not follow alarms");
    AST_FLASH_HEAT2: assert property (flash_heater2_o |->
        $past(alarm2_o.burnout || alarm2_o.overcur))
        else $error("heater 2 flash without alarm");
    AST_FLASH_LEAK1: assert property (flash_leak1_o |->
        $past(alarm1_o.short_leak))
        else $error("leak 1 flash without alarm");
    AST_HOLD: assert property (
        $past(resetn_i) && !$past(sample_valid_i) &&
        $stable(en) && $past(en) == $past(en, 2) |->
        $stable(alarm1_o) && $stable(alarm2_o))
        else $error("alarm changed without sample");
    AST_BURN_CAUSE: assert property (
        $rose(alarm1_o.burnout) |-> $past(sample_valid_i) &&
        $past(heat_out_i) && $past(burnout_detect_i))
        else $error("burnout rose without on sample");
    AST_OC_CAUSE: assert property (
        $rose(alarm2_o.overcur) |-> $past(sample_valid_i) &&
        $past(heat_out_i) && $past(overcur_use_i))
        else $error("overcurrent rose without on sample");
    AST_SHORT_CAUSE: assert property (
        $rose(alarm1_o.short_leak) |-> $past(sample_valid_i) &&
        !$past(heat_out_i) && $past(short_leak_alarm_i))
        else $error("short rose without off sample");
endmodule
`default_nettype wire

// file: dv/hcam_ct_model.sv
/*
 two current transformers: load current while heating, leakage while off.
 assumes the bench sets both currents in 0.1 A codes.
*/
`timescale 1ns/1ps
`default_nettype none
module hcam_ct_model (
    input wire logic heat_out_i,
    input wire hcam_pkg::cur_t load1_i,
    input wire hcam_pkg::cur_t load2_i,
    input wire hcam_pkg::cur_t leak1_i,
    input wire hcam_pkg::cur_t leak2_i,
    output hcam_pkg::cur_t ct1_o,
    output hcam_pkg::cur_t ct2_o
);
    assign ct1_o = heat_out_i ? load1_i : leak1_i;
    assign ct2_o = heat_out_i ? load2_i : leak2_i;
endmodule
`default_nettype wire

// file: dv/tb_heater_current_alarm_monitor.sv
/*
 testbench of the heater current alarm monitor, short pulse and blink.
 assumes the checker and current transformer model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_heater_current_alarm_monitor;
    logic clk_i = 1'b0, resetn_i = 1'b0, heat_out_i = 1'b0;
    logic sample_valid_i = 1'b0, burnout_detect_i = 1'b1;
    logic overcur_use_i = 1'b1, short_leak_alarm_i = 1'b1;
    hcam_pkg::cur_t load1 = 16'h0064, load2 = 16'h012C;
    hcam_pkg::cur_t leak1 = 16'h0258, leak2 = 16'h0032;
    hcam_pkg::cur_t thr_burnout1_i = 16'h00C8, thr_burnout2_i = 16'h0000;
    hcam_pkg::cur_t thr_overcur1_i = 16'h01F4, thr_overcur2_i = 16'h00FA;
    hcam_pkg::cur_t thr_short1_i = 16'h0000, thr_short2_i = 16'h0031;
    hcam_pkg::cur_t ct1_current_i, ct2_current_i;
    hcam_pkg::alarm_t alarm1_o, alarm2_o;
    hcam_pkg::monitor_t monitor1_o, monitor2_o;
    logic heater_alarm_lamp_o, flash_heater1_o, flash_heater2_o;
    logic flash_leak1_o, flash_leak2_o;
    hcam_pkg::alarm_t alarm2_one;
    hcam_pkg::monitor_t monitor2_one;
    int bad_count = 0;
    int cmp_count = 0;
    hcam_ct_model i_hcam_ct_model (.heat_out_i, .load1_i(load1),
        .load2_i(load2), .leak1_i(leak1), .leak2_i(leak2),
        .ct1_o(ct1_current_i), .ct2_o(ct2_current_i));
    heater_current_alarm_monitor #(.MIN_PULSE_CYC(20), .BLINK_CYC(4),
        .TWO_CT(1'b1)) i_heater_current_alarm_monitor (.clk_i, .resetn_i,
        .heat_out_i, .sample_valid_i, .ct1_current_i, .ct2_current_i,
        .burnout_detect_i, .overcur_use_i, .short_leak_alarm_i,
        .thr_burnout1_i, .thr_burnout2_i, .thr_overcur1_i, .thr_overcur2_i,
        .thr_short1_i, .thr_short2_i, .alarm1_o, .alarm2_o, .monitor1_o,
        .monitor2_o, .heater_alarm_lamp_o, .flash_heater1_o,
        .flash_heater2_o, .flash_leak1_o, .flash_leak2_o);
    // single current input fitted: channel 2 must stay silent
    heater_current_alarm_monitor #(.MIN_PULSE_CYC(20), .BLINK_CYC(4),
        .TWO_CT(1'b0)) i_heater_current_alarm_monitor_one (.clk_i,
        .resetn_i, .heat_out_i, .sample_valid_i, .ct1_current_i,
        .ct2_current_i, .burnout_detect_i, .overcur_use_i,
        .short_leak_alarm_i, .thr_burnout1_i, .thr_burnout2_i,
        .thr_overcur1_i, .thr_overcur2_i, .thr_short1_i, .thr_short2_i,
        .alarm1_o(), .alarm2_o(alarm2_one), .monitor1_o(),
        .monitor2_o(monitor2_one), .heater_alarm_lamp_o(),
        .flash_heater1_o(), .flash_heater2_o(), .flash_leak1_o(),
        .flash_leak2_o());
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one strobe after n cycles, outputs checked once lamp has settled
    task samp(input int n);
        cyc(n);
        sample_valid_i <= 1'b1;
        cyc(1);
        sample_valid_i <= 1'b0;
        cyc(2);
        #1;
    endtask
    // s selects heater1, heater2, leak1, leak2 flash
    task wait_hi(input int s);
        int i;
        logic [3:0] f;
        for (i = 0; i < 40; i++) begin
            cyc(1);
            #1;
            f = {flash_leak2_o, flash_leak1_o, flash_heater2_o,
                 flash_heater1_o};
            if (f[s] === 1'b1) break;
        end
        chk("flash", 1, i < 40);
        if (i >= 40) report_and_stop;
    endtask
    initial begin
        cyc(8);
        resetn_i <= 1'b1;
        heat_out_i <= 1'b1;
        samp(30);
        chk("alarm1", 3'b100, alarm1_o);
        chk("alarm2", 3'b010, alarm2_o);
        chk("alarm2 single", 3'b000, alarm2_one);
        chk("heater1", 16'h0064, monitor1_o.heater);
        chk("lamp", 1, heater_alarm_lamp_o);
        wait_hi(1);
        wait_hi(0);
        cyc(1);
        heat_out_i <= 1'b0;
        cyc(5);
        heat_out_i <= 1'b1;
        load1 <= 16'h012C;
        samp(8);
        chk("alarm1", 3'b100, alarm1_o);
        chk("heater1", 16'h0064, monitor1_o.heater);
        cyc(1);
        heat_out_i <= 1'b0;
        samp(30);
        chk("alarm1", 3'b101, alarm1_o);
        chk("alarm2", 3'b011, alarm2_o);
        chk("leak1", 16'hFFFF, monitor1_o.leak);
        chk("leak2", 16'h0032, monitor2_o.leak);
        chk("monitor2 single", 32'h0000_0000, monitor2_one);
        wait_hi(2);
        wait_hi(3);
        cyc(1);
        load1 <= 16'h00C8;
        load2 <= 16'h0258;
        thr_overcur1_i <= 16'h0000;
        thr_burnout2_i <= 16'h01F4;
        thr_overcur2_i <= 16'h01F4;
        heat_out_i <= 1'b1;
        samp(30);
        chk("alarm1", 3'b011, alarm1_o);
        chk("alarm2", 3'b101, alarm2_o);
        chk("heater2", 16'hFFFF, monitor2_o.heater);
        cyc(1);
        thr_short2_i <= 16'h01F4;
        heat_out_i <= 1'b0;
        samp(8);
        chk("alarm2", 3'b101, alarm2_o);
        cyc(1);
        burnout_detect_i <= 1'b0;
        overcur_use_i <= 1'b0;
        short_leak_alarm_i <= 1'b0;
        cyc(3);
        #1;
        chk("alarm1", 3'b000, alarm1_o);
        chk("monitor1", 32'h0000_0000, monitor1_o);
        chk("alarm2", 3'b000, alarm2_o);
        chk("lamp", 1'b0, heater_alarm_lamp_o);
        chk("flash", 4'h0, {flash_leak2_o, flash_leak1_o, flash_heater2_o,
            flash_heater1_o});
        report_and_stop;
    end
endmodule
bind heater_current_alarm_monitor hcam_assertions i_hcam_assertions (
    .clk_i, .resetn_i, .sample_valid_i, .heat_out_i, .burnout_detect_i,
    .overcur_use_i, .short_leak_alarm_i, .alarm1_o, .alarm2_o, .monitor1_o,
    .heater_alarm_lamp_o, .flash_heater2_o, .flash_leak1_o);
`default_nettype wire

// file: inc/hcam_cfg.svh
/*
 heater current alarm monitor constants: current codes, limits, timing.
 assumes currents in 0.1 A steps and a 125 MHz clock.
*/
`ifndef HCAM_CFG_SVH
`define HCAM_CFG_SVH
`define HCAM_CUR_W 16
`define HCAM_THR_OFF_LOW 16'h0000
`define HCAM_THR_FULL 16'h01F4
`define HCAM_MON_MAX 16'h0226
`define HCAM_OVF_CODE 16'hFFFF
`define HCAM_CLK_MHZ 125
`define HCAM_MIN_PULSE_MS 100
`define HCAM_MIN_PULSE_CYC (`HCAM_MIN_PULSE_MS * 1000 * `HCAM_CLK_MHZ)
`define HCAM_BLINK_CYC 62500000
`endif

// file: inc/hcam_pkg.sv
/*
 types of the heater current alarm monitor.
 assumes hcam_cfg.svh is on the include path.
*/
`default_nettype none
`include "hcam_cfg.svh"
package hcam_pkg;
    typedef logic [`HCAM_CUR_W-1:0] cur_t;
    typedef struct packed {
        logic burnout;
        logic overcur;
        logic short_leak;
    } alarm_t;
    typedef struct packed {
        cur_t heater;
        cur_t leak;
    } monitor_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ON = 2'b01,
        ST_OFF = 2'b11
    } phase_t;
endpackage
`default_nettype wire
